// [hw/irxhb_pkg.sv]
// package: register map, field layout and captured-header carriers
package irxhb_pkg;

  // ----------------------------------------------------------------
  // register map (byte offsets)
  // ----------------------------------------------------------------
  localparam int          ADDR_W             = 8;
  localparam int          DATA_W             = 16;
  localparam logic [7:0]  OFS_ISO_HDR_A      = 8'h44;
  localparam logic [7:0]  OFS_CIP_HDR_A      = 8'h46;
  localparam logic [7:0]  OFS_ISO_HDR_B      = 8'h48;
  localparam logic [7:0]  OFS_CIP_HDR_B      = 8'h4a;
  localparam logic [7:0]  OFS_RST_CTRL       = 8'h4c;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          ISO_EMI_LSB        = 7;
  localparam int          ISO_OE_BIT         = 6;
  localparam int          ISO_SID_LSB        = 0;
  localparam int          CIP_FMT_LSB        = 6;
  localparam int          CIP_FLAG_BIT       = 5;
  localparam int          CIP_STYPE_LSB      = 0;
  localparam int          RST_BRIDGE_B_BIT   = 15;
  localparam int          RST_STREAM_B_BIT   = 14;
  localparam int          RST_LINK_B_BIT     = 13;
  localparam int          RST_BRIDGE_A_BIT   = 7;
  localparam int          RST_STREAM_A_BIT   = 6;
  localparam int          RST_LINK_A_BIT     = 5;
  localparam logic [15:0] RST_CTRL_MASK      = 16'he0e0;
  localparam logic [15:0] RST_CTRL_RESET     = 16'h0000;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] copy_ctrl;
    logic       odd_even;
    logic [5:0] source_id;
    logic [5:0] format;
    logic       rate_flag;
    logic [4:0] source_type;
  } irxhb_hdr_t;

  typedef struct packed {
    logic bridge;
    logic stream_fifo;
    logic link_fifo;
  } irxhb_rst_t;

  localparam irxhb_hdr_t HDR_RESET = '0;

endpackage

// [hw/irxhb_regs.sv]
// register bank: received isochronous header fields and bridge reset control
// ------------------------------------------------------------------
// Summary of operation
// - copy-control bits at 8:7 of first register
// - odd/even bit at bit 6
// - six-bit source id at bits 5:0
// - six-bit format at bits 11:6 of second
// - bit 5 carries 50/60 or TSF flag
// - five-bit source type at bits 4:0
// - reserved reset bits read zero, write zero
// - bit 15 holds bridge B in reset
// - bit 7 holds bridge A in reset
// - bits 14/6 hold stream-side FIFO reset
// - bits 13/5 hold link-side FIFO reset
// - reset bits never self-clear
// - reserved header bits always read zero
// ------------------------------------------------------------------
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module irxhb_regs
  import irxhb_pkg::*;
(
  input  wire logic                       REF_CLK_I,
  input  wire logic                       RST_I,
  input  wire logic [irxhb_pkg::ADDR_W-1:0] ADDR_I,
  input  wire logic [irxhb_pkg::DATA_W-1:0] WDATA_I,
  input  wire logic                       WR_I,
  input  wire logic                       RD_I,
  output logic      [irxhb_pkg::DATA_W-1:0] RDATA_O,
  input  wire logic                       HDR_VALID_A_I,
  input  wire irxhb_pkg::irxhb_hdr_t      HDR_A_I,
  input  wire logic                       HDR_VALID_B_I,
  input  wire irxhb_pkg::irxhb_hdr_t      HDR_B_I,
  output irxhb_pkg::irxhb_rst_t           RST_A_O,
  output irxhb_pkg::irxhb_rst_t           RST_B_O
);
  import irxhb_pkg::*;

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  irxhb_hdr_t         hdr_a;
  irxhb_hdr_t         hdr_b;
  logic [DATA_W-1:0]  rst_ctrl;
  logic [DATA_W-1:0]  rdata;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic              sel_iso_a  = (ADDR_I == OFS_ISO_HDR_A);
  wire logic              sel_cip_a  = (ADDR_I == OFS_CIP_HDR_A);
  wire logic              sel_iso_b  = (ADDR_I == OFS_ISO_HDR_B);
  wire logic              sel_cip_b  = (ADDR_I == OFS_CIP_HDR_B);
  wire logic              sel_rst    = (ADDR_I == OFS_RST_CTRL);
  wire logic              sel_any    = sel_iso_a | sel_cip_a | sel_iso_b | sel_cip_b | sel_rst;
  wire logic [DATA_W-1:0] next_rst_ctrl = WDATA_I & RST_CTRL_MASK;

  function automatic logic [DATA_W-1:0] iso_word(input irxhb_hdr_t h);
    logic [DATA_W-1:0] w;
    w = '0;
    w[ISO_EMI_LSB +: 2] = h.copy_ctrl;
    w[ISO_OE_BIT] = h.odd_even;
    w[ISO_SID_LSB +: 6] = h.source_id;
    return w;
  endfunction

  function automatic logic [DATA_W-1:0] cip_word(input irxhb_hdr_t h);
    logic [DATA_W-1:0] w;
    w = '0;
    w[CIP_FMT_LSB +: 6] = h.format;
    w[CIP_FLAG_BIT] = h.rate_flag;
    w[CIP_STYPE_LSB +: 5] = h.source_type;
    return w;
  endfunction

  // unmapped addresses read zero
  wire logic [DATA_W-1:0] next_rdata =
      sel_iso_a ? iso_word(hdr_a) :
      sel_cip_a ? cip_word(hdr_a) :
      sel_iso_b ? iso_word(hdr_b) :
      sel_cip_b ? cip_word(hdr_b) :
      sel_rst   ? rst_ctrl        : '0;

  // ----------------------------------------------------------------
  // header capture
  // ----------------------------------------------------------------
  // capture per accepted packet
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
    begin
      hdr_a <= HDR_RESET;
      hdr_b <= HDR_RESET;
    end
    else
    begin
      if (HDR_VALID_A_I)
        hdr_a <= HDR_A_I;
      if (HDR_VALID_B_I)
        hdr_b <= HDR_B_I;
    end
  end

  // ----------------------------------------------------------------
  // reset control and read port
  // ----------------------------------------------------------------
  // held until software writes zero
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      rst_ctrl <= RST_CTRL_RESET;
    else if (WR_I && sel_rst)
      rst_ctrl <= next_rst_ctrl;
  end

  // read data valid only the cycle after the strobe
  always_ff @(posedge REF_CLK_I or posedge RST_I)
  begin
    if (RST_I)
      rdata <= '0;
    else if (RD_I)
      rdata <= next_rdata;
    else
      rdata <= '0;
  end

  assign RDATA_O = rdata;

  assign RST_B_O = irxhb_rst_t'({rst_ctrl[RST_BRIDGE_B_BIT],
                                 rst_ctrl[RST_STREAM_B_BIT],
                                 rst_ctrl[RST_LINK_B_BIT]});
  // channel A resets; transfers not policed here
  assign RST_A_O = irxhb_rst_t'({rst_ctrl[RST_BRIDGE_A_BIT],
                                 rst_ctrl[RST_STREAM_A_BIT],
                                 rst_ctrl[RST_LINK_A_BIT]});

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_rst_write_takes: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    WR_I && sel_rst |=> RST_B_O.bridge == $past(WDATA_I[RST_BRIDGE_B_BIT])
                       && RST_A_O.bridge == $past(WDATA_I[RST_BRIDGE_A_BIT]))
    else $error("bridge reset bit not written");
  a_fifo_rst_map: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    WR_I && sel_rst |=> RST_B_O.stream_fifo == $past(WDATA_I[RST_STREAM_B_BIT])
                       && RST_A_O.stream_fifo == $past(WDATA_I[RST_STREAM_A_BIT]))
    else $error("stream fifo reset mismatch");
  a_link_rst_map: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    WR_I && sel_rst |=> RST_B_O.link_fifo == $past(WDATA_I[RST_LINK_B_BIT])
                       && RST_A_O.link_fifo == $past(WDATA_I[RST_LINK_A_BIT]))
    else $error("link fifo reset mismatch");
  a_rst_no_selfclr: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !(WR_I && sel_rst) |=> $stable(rst_ctrl))
    else $error("reset control changed without write");
  a_rst_rsvd_zero: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    RD_I && sel_rst |=> RDATA_O[12:8] == 5'h00 && RDATA_O[4:0] == 5'h00)
    else $error("reserved reset bits nonzero");
  a_iso_read_a: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    RD_I && sel_iso_a |=> RDATA_O[15:9] == 7'h00
                         && RDATA_O[5:0] == $past(hdr_a.source_id)
                         && RDATA_O[8:7] == $past(hdr_a.copy_ctrl)
                         && RDATA_O[6] == $past(hdr_a.odd_even))
    else $error("first header register A wrong");
  a_cip_read_b: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    RD_I && sel_cip_b |=> RDATA_O[15:12] == 4'h0
                         && RDATA_O[11:6] == $past(hdr_b.format)
                         && RDATA_O[5] == $past(hdr_b.rate_flag)
                         && RDATA_O[4:0] == $past(hdr_b.source_type))
    else $error("second header register B wrong");
  a_hdr_capture: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    HDR_VALID_A_I |=> hdr_a == $past(HDR_A_I))
    else $error("header A not captured");
  a_hdr_hold: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !HDR_VALID_B_I |=> $stable(hdr_b))
    else $error("header B changed without packet");
  a_rdata_idle: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
    !RD_I |=> RDATA_O == 16'h0000)
    else $error("read data outside read cycle");

  // ----------------------------------------------------------------
  // per-field read checks
  // ----------------------------------------------------------------
  // header sampled at the strobe edge, so a packet landing mid-read is legal
  a_emi_read_b: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_iso_b
      |=> RDATA_O[8:7] == $past(hdr_b.copy_ctrl))
    else $error("copy control bits B wrong");

  a_oe_read_b: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_iso_b
      |=> RDATA_O[6] == $past(hdr_b.odd_even))
    else $error("odd even bit B wrong");

  a_sid_read_b: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_iso_b
      |=> RDATA_O[5:0] == $past(hdr_b.source_id))
    else $error("source id B wrong");

  a_iso_rsvd_b: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_iso_b
      |=> RDATA_O[15:9] == 7'h00)
    else $error("reserved first register B bits nonzero");

  a_fmt_read_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_cip_a
      |=> RDATA_O[11:6] == $past(hdr_a.format))
    else $error("format field A wrong");

  a_flag_read_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_cip_a
      |=> RDATA_O[5] == $past(hdr_a.rate_flag))
    else $error("rate flag A wrong");

  a_stype_read_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_cip_a
      |=> RDATA_O[4:0] == $past(hdr_a.source_type))
    else $error("source type A wrong");

  a_cip_rsvd_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_cip_a
      |=> RDATA_O[15:12] == 4'h0)
    else $error("reserved second register A bits nonzero");

  a_unmapped_zero: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && !sel_any
      |=> RDATA_O == 16'h0000)
    else $error("unmapped address read nonzero");

  // ----------------------------------------------------------------
  // reset control checks
  // ----------------------------------------------------------------
  a_rst_read_back: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      RD_I && sel_rst
      |=> RDATA_O == $past(rst_ctrl))
    else $error("reset control read back wrong");

  a_rd_after_wr: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      WR_I && sel_rst ##1 RD_I && sel_rst
      |=> RDATA_O == ($past(WDATA_I, 2) & RST_CTRL_MASK))
    else $error("reset control not held after write");

  a_rst_rsvd_store: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      (rst_ctrl & ~RST_CTRL_MASK) == 16'h0000)
    else $error("reserved reset bits stored");

  a_rst_bridge_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      WR_I && sel_rst
      |=> RST_A_O.bridge == $past(WDATA_I[RST_BRIDGE_A_BIT]))
    else $error("bridge A reset bit not written");

  a_rst_clear_b: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      WR_I && sel_rst && !WDATA_I[RST_BRIDGE_B_BIT]
      |=> !RST_B_O.bridge)
    else $error("bridge B reset not released");

  a_rst_clear_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      WR_I && sel_rst && !WDATA_I[RST_BRIDGE_A_BIT]
      |=> !RST_A_O.bridge)
    else $error("bridge A reset not released");

  a_stream_clear: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      WR_I && sel_rst && !WDATA_I[RST_STREAM_A_BIT] && !WDATA_I[RST_STREAM_B_BIT]
      |=> !RST_A_O.stream_fifo && !RST_B_O.stream_fifo)
    else $error("stream fifo reset not released");

  a_link_clear: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      WR_I && sel_rst && !WDATA_I[RST_LINK_A_BIT] && !WDATA_I[RST_LINK_B_BIT]
      |=> !RST_A_O.link_fifo && !RST_B_O.link_fifo)
    else $error("link fifo reset not released");

  // ----------------------------------------------------------------
  // header capture checks
  // ----------------------------------------------------------------
  a_hdr_capture_b: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      HDR_VALID_B_I
      |=> hdr_b == $past(HDR_B_I))
    else $error("header B not captured");

  a_hdr_hold_a: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      !HDR_VALID_A_I
      |=> $stable(hdr_a))
    else $error("header A changed without packet");

  a_hdr_a_no_write: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      WR_I && (sel_iso_a || sel_cip_a) && !HDR_VALID_A_I
      |=> $stable(hdr_a))
    else $error("header A taken a software write");

  a_hdr_b_no_write: assert property (
      @(posedge REF_CLK_I) disable iff (RST_I)
      WR_I && (sel_iso_b || sel_cip_b) && !HDR_VALID_B_I
      |=> $stable(hdr_b))
    else $error("header B taken a software write");


  c_read_hdr: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    HDR_VALID_A_I ##1 RD_I && sel_iso_a);
  c_rst_cycle: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    RST_A_O.bridge ##[1:20] !RST_A_O.bridge);
  c_rd_after_wr: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    WR_I && sel_rst ##1 RD_I && sel_rst);
  c_read_hdr_b: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    HDR_VALID_B_I ##1 RD_I && sel_cip_b);
  c_link_rst_b: cover property (@(posedge REF_CLK_I) disable iff (RST_I)
    RST_B_O.link_fifo ##[1:40] !RST_B_O.link_fifo);

endmodule

`default_nettype wire

// [tb/irxhb_regs_test.sv]
// bench: register read-back, header capture and bridge reset control
`timescale 1ns/1ps
`default_nettype none
module irxhb_regs_test;
  import irxhb_pkg::*;
  logic        clk, rst, wr, rd, hva, hvb, rd_d;
  logic [7:0]  addr;
  logic [15:0] wdata, rdata, v;
  irxhb_hdr_t  ha, hb;
  irxhb_rst_t  rsta, rstb;
  logic [15:0] exp_q[$];
  int          bad_count, checks, seed, i;

  irxhb_regs u_irxhb_regs (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HDR_VALID_A_I(hva), .HDR_A_I(ha),
    .HDR_VALID_B_I(hvb), .HDR_B_I(hb), .RST_A_O(rsta), .RST_B_O(rstb));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_rst(input logic [5:0] exp);
    #1 cmp16({10'h000, rstb, rsta}, {10'h000, exp});
  endtask

  task wrap_up;
    if (bad_count == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a; rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  function automatic logic [15:0] iso_of(input irxhb_hdr_t h);
    return {7'h00, h.copy_ctrl, h.odd_even, h.source_id};
  endfunction

  function automatic logic [15:0] cip_of(input irxhb_hdr_t h);
    return {4'h0, h.format, h.rate_flag, h.source_type};
  endfunction

  // ------------------------------------------------------------------
  // read monitor: data stands only in the cycle after the strobe
  // ------------------------------------------------------------------
  always @(posedge clk) rd_d <= rd & ~rst;
  always @(negedge clk)
    if (rd_d && exp_q.size() == 0)
      cmp16(rdata, 16'hdead);
    else if (rd_d)
      cmp16(rdata, exp_q.pop_front());
    else if (!rst)
      cmp16(rdata, 16'h0000);

  initial
  begin
    repeat (20000) @(posedge clk);
    bad_count++;
    wrap_up;
  end

  initial
  begin
    seed = 32'h1f055035;
    rst = 1'b1; wr = 1'b0; rd = 1'b0; hva = 1'b0; hvb = 1'b0; rd_d = 1'b0;
    addr = 8'h00; wdata = 16'h0000; ha = '0; hb = '0; bad_count = 0; checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    // zero after reset, unmapped 0x4e reads zero
    for (i = 0; i < 6; i++) rd_reg(8'h44 + 8'(2 * i), 16'h0000);
    // headers random in their low 17 bits (copy-control, odd/even and source id bit 5 stay zero) captured and read back on both channels
    for (i = 0; i < 6; i++)
    begin
      @(posedge clk);
      ha <= irxhb_hdr_t'(17'($random(seed)));
      hb <= irxhb_hdr_t'(17'($random(seed)));
      hva <= 1'b1; hvb <= 1'b1;
      @(posedge clk);
      hva <= 1'b0; hvb <= 1'b0;
      rd_reg(8'h44, iso_of(ha));
      rd_reg(8'h46, cip_of(ha));
      rd_reg(8'h48, iso_of(hb));
      rd_reg(8'h4a, cip_of(hb));
    end
    // header registers shrug off writes
    for (i = 0; i < 4; i++) wr_reg(8'h44 + 8'(2 * i), 16'hffff);
    rd_reg(8'h44, iso_of(ha));
    rd_reg(8'h4a, cip_of(hb));
    // header traffic has stopped before any reset bit is set
    // each control bit alone; reserved positions always written zero
    for (i = 0; i < 16; i++)
    begin
      v = 16'h0001 << i;
      wr_reg(8'h4c, v & 16'he0e0);
      cmp_rst({v[15], v[14], v[13], v[7], v[6], v[5]});
      rd_reg(8'h4c, v & 16'he0e0);
    end
    // all set, held without self-clearing, then released
    wr_reg(8'h4c, 16'he0e0);
    repeat (8) @(posedge clk);
    cmp_rst(6'h3f);
    rd_reg(8'h4c, 16'he0e0);
    wr_reg(8'h4c, 16'h0000);
    cmp_rst(6'h00);
    for (i = 0; i < 20 && exp_q.size() > 0; i++) @(posedge clk);
    @(posedge clk);
    if (exp_q.size() > 0) bad_count++;
    wrap_up;
  end
endmodule
`default_nettype wire
